// *** aif_pkg.sv ***
// Purpose: Constants shared by the ADC interrupt flag block.
// Assumes: 32-bit register data, byte offsets as word addresses.
// Notes:   Flag positions are common to every flag-shaped register.
`default_nettype none
package aif_pkg;
    // ==========================================
    // Register offsets
    // ==========================================
    localparam logic [15:0] OFS_INDEX      = 16'h1020;
    localparam logic [15:0] OFS_MASK       = 16'h1028;
    localparam logic [15:0] OFS_RAW        = 16'h1030;
    localparam logic [15:0] OFS_MASKED     = 16'h1038;
    localparam logic [15:0] OFS_MASKED_EX  = 16'h1040;
    localparam logic [15:0] OFS_CLEAR      = 16'h1048;
    localparam logic [15:0] OFS_CLEAR_EX   = 16'h1050;

    // ==========================================
    // Flag positions
    // ==========================================
    localparam int BIT_OVERFLOW  = 0;
    localparam int BIT_TIMEOUT   = 1;
    localparam int BIT_ABOVE     = 2;
    localparam int BIT_BELOW     = 3;
    localparam int BIT_INPUT     = 4;
    localparam int BIT_DMA_DONE  = 5;
    localparam int BIT_UNDERFLOW = 6;
    localparam int BIT_SEQ_DONE  = 7;
    localparam int BIT_RESULT0   = 8;
    localparam int FLAG_W        = 12;

    // ==========================================
    // Field groups and reset values
    // ==========================================
    // Mask bits that software may write
    localparam logic [11:0] MASK_WRITABLE = 12'hf5f;
    // Flags cleared by the main clear register
    localparam logic [11:0] CLEAR_MAIN    = 12'hfd0;
    // Flags cleared by the extended clear register
    localparam logic [11:0] CLEAR_EXT     = 12'h02f;
    // Only the input event is gated into the extended masked view
    localparam logic [11:0] MASKED_EX_SEL = 12'h010;
    localparam logic [11:0] RAW_RESET     = 12'h000;
    localparam logic [11:0] MASK_RESET    = 12'h000;
    localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;
endpackage
`default_nettype wire

// *** aif_top.sv ***
// Purpose: Raw, masked and index views of the ADC interrupt flags.
// Assumes: Event inputs are one-cycle pulses synchronous to mclk_i.
// Notes:   Read data appear only in the cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module aif_top (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic      [31:0] rdata_o,
    input  wire logic [3:0]  result_load_i,
    input  wire logic [3:0]  result_read_i,
    input  wire logic        underflow_i,
    input  wire logic        dma_done_i,
    input  wire logic        input_event_i,
    input  wire logic        below_i,
    input  wire logic        above_i,
    input  wire logic        timeout_i,
    input  wire logic        overflow_i,
    input  wire logic        seq_done_i,
    output logic             irq_o
);

    // ==========================================
    // State
    // ==========================================
    typedef struct packed {
        logic [11:0] mask;
        logic [11:0] raw;
        logic [31:0] rdata;
    } aif_state_s;

    aif_state_s  s_q;
    aif_state_s  s_d;
    logic [11:0] set_v;
    logic [11:0] clr_v;
    logic [11:0] masked_v;
    logic [3:0]  index_v;
    logic        idx_rd;

    // Lowest pending masked flag wins; 0 means none pending
    function automatic logic [3:0] aif_index(input logic [11:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = aif_pkg::FLAG_W - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                r = 4'(i + 1);
            end
        end
        return r;
    endfunction

    // Bus write qualifier shared by all write-one registers; the strobe comes in
    // as an argument so that assertions see its sampled value like the address
    function automatic logic aif_wr(input logic        w,
                                    input logic [15:0] a,
                                    input logic [15:0] ofs);
        return w && (a == ofs);
    endfunction

    // ==========================================
    // Derived views
    // ==========================================
    // Mask and raw combine bitwise so software sees pending enabled events
    assign masked_v = s_q.mask & s_q.raw;
    assign index_v  = aif_index(masked_v);
    assign idx_rd   = re_i && (addr_i == aif_pkg::OFS_INDEX);
    assign irq_o    = |masked_v;
    assign rdata_o  = s_q.rdata;

    // ==========================================
    // Set and clear sources
    // ==========================================
    // Raw capture ignores the mask so polling works with interrupts off
    always_comb
    begin
        set_v = 12'h000;
        set_v[11:8] = result_load_i;
        set_v[aif_pkg::BIT_SEQ_DONE]  = seq_done_i;
        set_v[aif_pkg::BIT_UNDERFLOW] = underflow_i;
        set_v[aif_pkg::BIT_DMA_DONE]  = dma_done_i;
        set_v[aif_pkg::BIT_INPUT]     = input_event_i;
        set_v[aif_pkg::BIT_BELOW]     = below_i;
        set_v[aif_pkg::BIT_ABOVE]     = above_i;
        set_v[aif_pkg::BIT_TIMEOUT]   = timeout_i;
        set_v[aif_pkg::BIT_OVERFLOW]  = overflow_i;
    end

    // Clears ignore the mask; an index read drops only the flag it reports
    always_comb
    begin
        clr_v = 12'h000;
        if (aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR))
        begin
            clr_v = clr_v | (wdata_i[11:0] & aif_pkg::CLEAR_MAIN);
        end
        if (aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR_EX))
        begin
            clr_v = clr_v | (wdata_i[11:0] & aif_pkg::CLEAR_EXT);
        end
        clr_v[11:8] = clr_v[11:8] | result_read_i;
        if (idx_rd && (index_v != 4'h0))
        begin
            clr_v[index_v - 4'h1] = 1'b1;
        end
    end

    // ==========================================
    // Next state
    // ==========================================
    always_comb
    begin
        s_d = s_q;
        // Set beats clear so a same-cycle event is not lost
        s_d.raw = (s_q.raw & ~clr_v) | set_v;
        if (aif_wr(we_i, addr_i, aif_pkg::OFS_MASK))
        begin
            s_d.mask = wdata_i[11:0] & aif_pkg::MASK_WRITABLE;
        end
        // Read data live one cycle only; unmapped reads return zero
        s_d.rdata = 32'h0000_0000;
        if (re_i)
        begin
            unique case (addr_i)
                aif_pkg::OFS_RAW:
                    s_d.rdata = {20'h00000, s_q.raw};
                aif_pkg::OFS_MASK:
                    s_d.rdata = {20'h00000, s_q.mask};
                aif_pkg::OFS_MASKED:
                    s_d.rdata = {20'h00000, masked_v};
                aif_pkg::OFS_MASKED_EX:
                    s_d.rdata = {20'h00000, masked_v & aif_pkg::MASKED_EX_SEL};
                aif_pkg::OFS_INDEX:
                    s_d.rdata = {28'h0000000, index_v};
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // Synchronous reset puts every register at its reset value
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            s_q.mask  <= aif_pkg::MASK_RESET;
            s_q.raw   <= aif_pkg::RAW_RESET;
            s_q.rdata <= aif_pkg::RDATA_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Assertions
    // ==========================================
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // Raw capture must not depend on the mask, or polling would miss events
    property p_poll;
        (s_q.mask == 12'h000) && overflow_i |=> s_q.raw[0] && !masked_v[0];
    endproperty
    a_poll: assert property (p_poll) else $error("raw flag missing while masked");

    // Raw view is read back unfiltered in the following cycle
    property p_raw_read;
        re_i && (addr_i == aif_pkg::OFS_RAW) |=> rdata_o == {20'h00000, $past(s_q.raw)};
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("raw read wrong");

    // Main clear drops a result flag unless a new result lands at once
    property p_clear;
        aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR) && wdata_i[8] && !result_load_i[0]
            |=> !s_q.raw[8];
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not drop flag");

    // Sequence done has no index-only exit; the main clear drops it
    property p_seq_clr;
        aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR) && wdata_i[7] && !seq_done_i |=> !s_q.raw[7];
    endproperty
    a_seq_clr: assert property (p_seq_clr) else $error("sequence flag not cleared");

    // A result flag survives idle cycles until read or cleared
    property p_result;
        result_load_i[1] ##1 (!result_read_i[1] && !we_i && !re_i)[*2]
            |-> s_q.raw[9];
    endproperty
    a_result: assert property (p_result) else $error("result flag lost");

    // Reading a result register drops its ready flag
    property p_result_read;
        result_read_i[2] && !result_load_i[2] |=> !s_q.raw[10];
    endproperty
    a_result_read: assert property (p_result_read) else $error("result read did not clear");

    // Underflow answers the main clear register
    property p_under;
        aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR) && wdata_i[6] && !underflow_i |=> !s_q.raw[6];
    endproperty
    a_under: assert property (p_under) else $error("underflow not cleared");

    // An index read that reports underflow must drop it
    property p_under_idx;
        idx_rd && (index_v == 4'h7) && !underflow_i |=> !s_q.raw[6];
    endproperty
    a_under_idx: assert property (p_under_idx) else $error("underflow kept after index read");

    // DMA done answers the extended clear register
    property p_dma;
        aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR_EX) && wdata_i[5] && !dma_done_i |=> !s_q.raw[5];
    endproperty
    a_dma: assert property (p_dma) else $error("dma flag not cleared");

    // Read-only mask positions stay zero whatever software writes
    property p_mask_ro;
        !s_q.mask[aif_pkg::BIT_SEQ_DONE] && !s_q.mask[aif_pkg::BIT_DMA_DONE];
    endproperty
    a_mask_ro: assert property (p_mask_ro) else $error("read-only mask bit set");

    // Both window events in one cycle must set both flags
    property p_window;
        below_i && above_i |=> s_q.raw[3] && s_q.raw[2];
    endproperty
    a_window: assert property (p_window) else $error("window flag missing");

    // Low-threshold event arriving alone
    property p_below;
        below_i |=> s_q.raw[aif_pkg::BIT_BELOW];
    endproperty
    a_below: assert property (p_below) else $error("below flag missing");

    // High-threshold event arriving alone
    property p_above;
        above_i |=> s_q.raw[aif_pkg::BIT_ABOVE];
    endproperty
    a_above: assert property (p_above) else $error("above flag missing");

    // Window flags drop together on their extended clear bits
    property p_window_clr;
        aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR_EX) && wdata_i[3] && wdata_i[2] && !below_i && !above_i
            |=> !s_q.raw[3] && !s_q.raw[2];
    endproperty
    a_window_clr: assert property (p_window_clr) else $error("window flags not cleared");

    // Index read reporting the timeout flag clears it and returns its code
    property p_index;
        idx_rd && (index_v == 4'h2) && !timeout_i |=> !s_q.raw[1] && (rdata_o == 32'h0000_0002);
    endproperty
    a_index: assert property (p_index) else $error("index read did not clear");

    // Timeout answers the extended clear register
    property p_timeout_clr;
        aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR_EX) && wdata_i[1] && !timeout_i |=> !s_q.raw[1];
    endproperty
    a_timeout_clr: assert property (p_timeout_clr) else $error("timeout flag not cleared");

    // Overflow answers the extended clear register
    property p_overflow_clr;
        aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR_EX) && wdata_i[0] && !overflow_i |=> !s_q.raw[0];
    endproperty
    a_overflow_clr: assert property (p_overflow_clr) else $error("overflow flag not cleared");

    // The main clear register must leave the overflow flag alone
    property p_main_spares;
        aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR) && s_q.raw[0] |=> s_q.raw[0];
    endproperty
    a_main_spares: assert property (p_main_spares) else $error("main clear dropped overflow");

    // Sequence done event is captured on the next edge
    property p_seq;
        seq_done_i |=> s_q.raw[7];
    endproperty
    a_seq: assert property (p_seq) else $error("sequence flag missing");

    // Only mask bit 4 passes into the extended masked view
    property p_masked_ex;
        re_i && (addr_i == aif_pkg::OFS_MASKED_EX)
            |=> rdata_o == {20'h00000, $past(masked_v) & aif_pkg::MASKED_EX_SEL};
    endproperty
    a_masked_ex: assert property (p_masked_ex) else $error("extended masked wrong");

    // Masked view read back as mask AND raw
    property p_masked;
        re_i && (addr_i == aif_pkg::OFS_MASKED) |=> rdata_o == {20'h00000, $past(s_q.mask & s_q.raw)};
    endproperty
    a_masked: assert property (p_masked) else $error("masked status wrong");

    // A mask write keeps only the writable positions
    property p_mask_write;
        aif_wr(we_i, addr_i, aif_pkg::OFS_MASK) |=> s_q.mask == ($past(wdata_i[11:0]) & aif_pkg::MASK_WRITABLE);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write wrong");

    // An unmasked overflow is the lowest code the index can report
    property p_index_low;
        idx_rd && s_q.mask[0] && s_q.raw[0] |=> rdata_o == 32'h0000_0001;
    endproperty
    a_index_low: assert property (p_index_low) else $error("index missed unmasked flag");

    // With nothing unmasked the index reads zero
    property p_index_zero;
        idx_rd && (masked_v == 12'h000) |=> rdata_o == 32'h0000_0000;
    endproperty
    a_index_zero: assert property (p_index_zero) else $error("index showed masked flag");

    // Interrupt line follows the masked status without delay
    property p_irq;
        irq_o == ((s_q.mask & s_q.raw) != 12'h000);
    endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with status");

    // ==========================================
    // Coverage
    // ==========================================
    // One cover for each main scenario, including a set racing its clear
    c_poll:     cover property (overflow_i ##1 idx_rd);
    c_irq:      cover property (!irq_o ##1 irq_o ##[1:20] !irq_o);
    c_race:     cover property (aif_wr(we_i, addr_i, aif_pkg::OFS_CLEAR_EX) && wdata_i[0] && overflow_i);
    c_index:    cover property (idx_rd && (index_v != 4'h0) ##1 (rdata_o != 32'h0000_0000));
    c_mask_off: cover property ((s_q.raw != 12'h000) && (s_q.mask == 12'h000));

endmodule // aif_top
`default_nettype wire

// *** aif_tb.sv ***
// Purpose: Self-checking bench for the ADC interrupt flag block.
// Assumes: Register reads return data exactly one cycle after the strobe.
// Notes:   Events are driven as one-cycle pulses from one vector.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        mclk_i    = 1'b0;
    logic        rst_i     = 1'b1;
    logic [15:0] addr_i    = 16'h0000;
    logic [31:0] wdata_i   = 32'h0000_0000;
    logic        we_i      = 1'b0;
    logic        re_i      = 1'b0;
    logic [11:0] ev_q      = 12'h000;
    logic [3:0]  rrd_q     = 4'h0;
    logic [31:0] rdata_o;
    logic        irq_o;
    int          error_cnt = 0;
    int          checked   = 0;

    // ==========================================
    // Clock and design
    // ==========================================
    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;

    // Event vector bit i drives the event that sets raw flag i
    aif_top aif_top_i (
        .mclk_i        (mclk_i),
        .rst_i         (rst_i),
        .addr_i        (addr_i),
        .wdata_i       (wdata_i),
        .we_i          (we_i),
        .re_i          (re_i),
        .rdata_o       (rdata_o),
        .result_load_i (ev_q[11:8]),
        .result_read_i (rrd_q),
        .underflow_i   (ev_q[6]),
        .dma_done_i    (ev_q[5]),
        .input_event_i (ev_q[4]),
        .below_i       (ev_q[3]),
        .above_i       (ev_q[2]),
        .timeout_i     (ev_q[1]),
        .overflow_i    (ev_q[0]),
        .seq_done_i    (ev_q[7]),
        .irq_o         (irq_o)
    );

    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        we_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        we_i    <= 1'b0;
        #1;
    endtask

    // Data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        re_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        re_i   <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    task automatic pulse(input logic [11:0] v, input logic [3:0] r);
        @(posedge mclk_i);
        ev_q  <= v;
        rrd_q <= r;
        @(posedge mclk_i);
        ev_q  <= 12'h000;
        rrd_q <= 4'h0;
        #1;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_reset();
        rd(aif_pkg::OFS_RAW, 32'h0000_0000);
        rd(aif_pkg::OFS_MASK, 32'h0000_0000);
        rd(aif_pkg::OFS_MASKED, 32'h0000_0000);
        rd(16'h1234, 32'h0000_0000);
        chk({31'h0, irq_o}, 32'h0000_0000);
        wr(aif_pkg::OFS_RAW, 32'h0000_0fff);
        rd(aif_pkg::OFS_RAW, 32'h0000_0000);
        $display("test reset done");
    endtask

    // Every event sets its own flag while all masks are off
    task automatic t_flags();
        for (int i = 0; i < 12; i++)
        begin
            pulse(12'h001 << i, 4'h0);
            rd(aif_pkg::OFS_RAW, (32'h2 << i) - 32'h1);
        end
        chk({31'h0, irq_o}, 32'h0000_0000);
        wr(aif_pkg::OFS_CLEAR, 32'h0000_0fff);
        rd(aif_pkg::OFS_RAW, 32'h0000_002f);
        wr(aif_pkg::OFS_CLEAR_EX, 32'h0000_0fff);
        rd(aif_pkg::OFS_RAW, 32'h0000_0000);
        $display("test flags done");
    endtask

    task automatic t_mask();
        wr(aif_pkg::OFS_MASK, 32'hffff_ffff);
        rd(aif_pkg::OFS_MASK, 32'h0000_0f5f);
        chk({31'h0, irq_o}, 32'h0000_0000);
        pulse(12'h041, 4'h0);
        chk({31'h0, irq_o}, 32'h0000_0001);
        rd(aif_pkg::OFS_MASKED, 32'h0000_0041);
        wr(aif_pkg::OFS_MASK, 32'h0000_0000);
        chk({31'h0, irq_o}, 32'h0000_0000);
        rd(aif_pkg::OFS_RAW, 32'h0000_0041);
        rd(aif_pkg::OFS_MASKED, 32'h0000_0000);
        rd(aif_pkg::OFS_INDEX, 32'h0000_0000);
        wr(aif_pkg::OFS_MASK, 32'h0000_0fff);
        rd(aif_pkg::OFS_INDEX, 32'h0000_0001);
        rd(aif_pkg::OFS_RAW, 32'h0000_0040);
        rd(aif_pkg::OFS_INDEX, 32'h0000_0007);
        rd(aif_pkg::OFS_RAW, 32'h0000_0000);
        chk({31'h0, irq_o}, 32'h0000_0000);
        $display("test mask done");
    endtask

    task automatic t_misc();
        pulse(12'h010, 4'h0);
        rd(aif_pkg::OFS_MASKED_EX, 32'h0000_0010);
        wr(aif_pkg::OFS_MASK, 32'h0000_0000);
        rd(aif_pkg::OFS_MASKED_EX, 32'h0000_0000);
        // Result 1 then sits through two idle cycles while result 2 is read
        pulse(12'h600, 4'h0);
        pulse(12'h000, 4'h4);
        rd(aif_pkg::OFS_RAW, 32'h0000_0210);
        wr(aif_pkg::OFS_CLEAR, 32'h0000_0210);
        rd(aif_pkg::OFS_RAW, 32'h0000_0000);
        // Both window events at once, then an unmasked timeout for the index
        pulse(12'h00c, 4'h0);
        wr(aif_pkg::OFS_MASK, 32'h0000_0002);
        pulse(12'h002, 4'h0);
        chk({31'h0, irq_o}, 32'h0000_0001);
        rd(aif_pkg::OFS_INDEX, 32'h0000_0002);
        rd(aif_pkg::OFS_RAW, 32'h0000_000c);
        wr(aif_pkg::OFS_CLEAR_EX, 32'h0000_000c);
        rd(aif_pkg::OFS_RAW, 32'h0000_0000);
        $display("test misc done");
    endtask

    // ==========================================
    // Main sequence and watchdog
    // ==========================================
    // Reset held for 12 cycles, then scenarios in order
    initial
    begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset();
        t_flags();
        t_mask();
        t_misc();
        give_verdict();
    end

    // Tests need well under 1000 cycles; allow twenty times that
    initial
    begin
        #200000;
        error_cnt++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
